/* File: verilog/fb_prescaler_defs.vh */
// Purpose: Constants for the feedback prescaler and status pin selector
// Assumes: APB byte address is four times the register index
// Notes: Definitions only
`ifndef FB_PRESCALER_DEFS_VH
`define FB_PRESCALER_DEFS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define FB_IDX_CTRL 10'h016
`define FB_IDX_STAT_SEL 10'h017
`define FB_IDX_A_CNT 10'h013
`define FB_IDX_B_CNT 10'h014
`define FB_IDX_STAT_LOCK 10'h01d
`define FB_ADDR_CTRL {`FB_IDX_CTRL, 2'b00}
`define FB_ADDR_STAT_SEL {`FB_IDX_STAT_SEL, 2'b00}
`define FB_ADDR_A_CNT {`FB_IDX_A_CNT, 2'b00}
`define FB_ADDR_B_CNT {`FB_IDX_B_CNT, 2'b00}
`define FB_ADDR_STAT_LOCK {`FB_IDX_STAT_LOCK, 2'b00}
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FB_BYPASS_BIT 3
`define FB_PRE_LSB 0
`define FB_PRE_MSB 2
`define FB_SEL_LSB 2
`define FB_SEL_MSB 7
`define FB_LOCK_BIT 7
`define FB_CTRL_RST 8'h06
`define FB_SEL_RST 8'h00
`define FB_A_RST 8'h00
`define FB_B_RST 8'h03
`define FB_LOCK_RST 8'h00
// ----------------------------------------
// Prescaler codes
// ----------------------------------------
`define FB_PRE_FIX1 3'h0
`define FB_PRE_FIX2 3'h1
`define FB_PRE_DUAL23 3'h2
`define FB_PRE_DUAL45 3'h3
`define FB_PRE_DUAL89 3'h4
`define FB_PRE_DUAL1617 3'h5
`define FB_PRE_DUAL3233 3'h6
`define FB_PRE_FIX3 3'h7
// ----------------------------------------
// Status pin selector codes
// ----------------------------------------
`define FB_SEL_LOW 6'h00
`define FB_SEL_NDIV 6'h01
`define FB_SEL_RDIV 6'h02
`define FB_SEL_ADIV 6'h03
`define FB_SEL_PRE 6'h04
`define FB_SEL_UP 6'h05
`define FB_SEL_DN 6'h06
`endif

/* File: verilog/mod_counter.v */
// Purpose: Free running modulo counter with terminal pulse
// Assumes: Modulus of zero or one gives a pulse every enabled cycle
// Notes: Used for prescaler and B counter stages
`timescale 1ns/1ps
`default_nettype none
module mod_counter (
    input wire pclk, // Clock
    input wire presetn, // Async reset, active low
    input wire en, // Count enable
    input wire [7:0] modulus, // Divide ratio
    output reg [7:0] count, // Current count
    output wire term // Last count of the cycle
);
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    assign term = en && (count + 8'h01 >= modulus);
    // Counts up and wraps at the modulus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 8'h00;
        end else if (term) begin
            count <= 8'h00;
        end else if (en) begin
            count <= count + 8'h01;
        end
    end
endmodule // mod_counter
`default_nettype wire

/* File: verilog/feedback_prescaler_status_mux.v */
// Purpose: Feedback divider prescaler, B bypass and status pin selector
// Assumes: Oscillator input is a clock enable on pclk; APB slave, 32-bit data
// Notes: Feedback division is P*B+A in dual modulus modes
// Overview of operation
// - The B bypass bit acts only while a fixed divide prescaler mode is chosen.
// - With bypass set the B counter divides by one, else it counts normally.
// - A three-bit field picks the prescaler mode, code zero being divide by one.
// - In a dual modulus mode the larger modulus is used while A is not zero.
// - After reset the prescaler sits in the 32/33 dual modulus mode.
// - A six-bit selector drives the status pin, zero low and one the N output.
// - Codes two to six route R output, A output, prescaler output, up and down.
// - The feedback divider is prescaler plus A and B counters, fed to the detector.
`timescale 1ns/1ps
`default_nettype none
`include "fb_prescaler_defs.vh"
module feedback_prescaler_status_mux (
    input wire pclk, // APB clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire osc_en, // Prescaler input clock enable
    input wire rdiv_out, // Delayed reference divider output
    input wire ndiv_delayed, // Delayed feedback divider output
    input wire phase_freq_detector_up, // Phase detector up pulse
    input wire phase_freq_detector_dn, // Phase detector down pulse
    output reg fb_out, // Feedback divider output to phase detector
    output reg adiv_out, // A divider output
    output reg pre_out, // Prescaler output
    output reg status_pin // Status pin level
);
    reg [7:0] ctrl;
    reg [7:0] stat_sel;
    reg [7:0] a_cnt;
    reg [7:0] b_cnt;
    reg [7:0] stat_lock;
    reg [7:0] pre_mod;
    reg [7:0] b_mod;
    reg [7:0] a_left;
    reg fixed_divide_mode;
    reg next_status;
    wire [2:0] pre_code;
    wire pre_term;
    wire b_term;
    wire bypass_eff;
    wire wr_en;
    wire rd_en;
    wire addr_ok;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign addr_ok = (paddr == `FB_ADDR_CTRL) || (paddr == `FB_ADDR_STAT_SEL) ||
                     (paddr == `FB_ADDR_A_CNT) || (paddr == `FB_ADDR_B_CNT) ||
                     (paddr == `FB_ADDR_STAT_LOCK);
    assign pslverr = psel && penable && !addr_ok;

    // Register writes; selector holds while the lock bit is set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `FB_CTRL_RST;
            stat_sel <= `FB_SEL_RST;
            a_cnt <= `FB_A_RST;
            b_cnt <= `FB_B_RST;
            stat_lock <= `FB_LOCK_RST;
        end else if (wr_en) begin
            case (paddr)
                `FB_ADDR_CTRL: ctrl <= pwdata[7:0];
                `FB_ADDR_STAT_SEL: begin
                    if (!stat_lock[`FB_LOCK_BIT]) begin
                        stat_sel <= {pwdata[7:2], 2'b00};
                    end
                end
                `FB_ADDR_A_CNT: a_cnt <= {2'b00, pwdata[5:0]};
                `FB_ADDR_B_CNT: b_cnt <= pwdata[7:0];
                `FB_ADDR_STAT_LOCK: stat_lock <= {pwdata[7], 7'h00};
                default: ctrl <= ctrl;
            endcase
        end
    end

    // Read data register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `FB_ADDR_CTRL: prdata <= {24'h000000, ctrl};
                `FB_ADDR_STAT_SEL: prdata <= {24'h000000, stat_sel};
                `FB_ADDR_A_CNT: prdata <= {24'h000000, a_cnt};
                `FB_ADDR_B_CNT: prdata <= {24'h000000, b_cnt};
                `FB_ADDR_STAT_LOCK: prdata <= {24'h000000, stat_lock};
                default: prdata <= 32'h00000000;
            endcase
        end else if (rd_en) begin
            prdata <= prdata;
        end
    end

    // ----------------------------------------
    // Prescaler modulus
    // ----------------------------------------
    assign pre_code = ctrl[`FB_PRE_MSB:`FB_PRE_LSB];

    // Modulus per mode; A nonzero and not yet spent picks the larger one
    always @* begin
        fixed_divide_mode = 1'b0;
        case (pre_code)
            `FB_PRE_FIX1: begin
                pre_mod = 8'h01;
                fixed_divide_mode = 1'b1;
            end
            `FB_PRE_FIX2: begin
                pre_mod = 8'h02;
                fixed_divide_mode = 1'b1;
            end
            `FB_PRE_DUAL23: pre_mod = (a_left != 8'h00) ? 8'h03 : 8'h02;
            `FB_PRE_DUAL45: pre_mod = (a_left != 8'h00) ? 8'h05 : 8'h04;
            `FB_PRE_DUAL89: pre_mod = (a_left != 8'h00) ? 8'h09 : 8'h08;
            `FB_PRE_DUAL1617: pre_mod = (a_left != 8'h00) ? 8'h11 : 8'h10;
            `FB_PRE_DUAL3233: pre_mod = (a_left != 8'h00) ? 8'h21 : 8'h20;
            `FB_PRE_FIX3: begin
                pre_mod = 8'h03;
                fixed_divide_mode = 1'b1;
            end
            default: pre_mod = 8'h01;
        endcase
    end

    // Bypass honoured only in fixed divide modes
    assign bypass_eff = ctrl[`FB_BYPASS_BIT] && fixed_divide_mode;
    always @* begin
        b_mod = bypass_eff ? 8'h01 : b_cnt;
    end

    // ----------------------------------------
    // Divider chain
    // ----------------------------------------
    mod_counter u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .en(osc_en),
        .modulus(pre_mod),
        .count(),
        .term(pre_term)
    );

    mod_counter u_b (
        .pclk(pclk),
        .presetn(presetn),
        .en(pre_term),
        .modulus(b_mod),
        .count(),
        .term(b_term)
    );

    // A swallow count reloads at each feedback cycle; outputs registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_left <= 8'h00;
            fb_out <= 1'b0;
            adiv_out <= 1'b0;
            pre_out <= 1'b0;
        end else begin
            if (b_term || fixed_divide_mode) begin
                a_left <= fixed_divide_mode ? 8'h00 : a_cnt;
            end else if (pre_term && a_left != 8'h00) begin
                a_left <= a_left - 8'h01;
            end
            fb_out <= b_term;
            adiv_out <= pre_term && (a_left == 8'h01);
            pre_out <= pre_term;
        end
    end

    // ----------------------------------------
    // Status pin selector
    // ----------------------------------------
    always @* begin
        case (stat_sel[`FB_SEL_MSB:`FB_SEL_LSB])
            `FB_SEL_LOW: next_status = 1'b0;
            `FB_SEL_NDIV: next_status = ndiv_delayed;
            `FB_SEL_RDIV: next_status = rdiv_out;
            `FB_SEL_ADIV: next_status = adiv_out;
            `FB_SEL_PRE: next_status = pre_out;
            `FB_SEL_UP: next_status = phase_freq_detector_up;
            `FB_SEL_DN: next_status = phase_freq_detector_dn;
            default: next_status = 1'b0;
        endcase
    end

    // Registered status pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_pin <= 1'b0;
        end else begin
            status_pin <= next_status;
        end
    end
endmodule // feedback_prescaler_status_mux
`default_nettype wire

/* File: bench/fb_status_checker.sv */
// Purpose: Port assertions for the prescaler and status pin block
// Assumes: One clock domain; APB slave answers in the first access cycle
// Notes: Mirrors selector and lock writes to predict the status pin
`timescale 1ns/1ps
`default_nettype none
`include "fb_prescaler_defs.vh"
module fb_status_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic osc_en, // Prescaler input enable
    input wire logic rdiv_out, // Reference divider
    input wire logic ndiv_delayed, // Feedback divider
    input wire logic phase_freq_detector_up, // Detector up
    input wire logic phase_freq_detector_dn, // Detector down
    input wire logic fb_out, // Feedback pulse
    input wire logic adiv_out, // A divider pulse
    input wire logic pre_out, // Prescaler pulse
    input wire logic status_pin // Status pin
);
    // ----------------------------------------
    // Mirror of the pin steering state
    // ----------------------------------------
    logic lock;
    logic [5:0] sel;
    wire acc = psel && penable;
    wire mapped = paddr == `FB_ADDR_A_CNT || paddr == `FB_ADDR_B_CNT || paddr == `FB_ADDR_CTRL
        || paddr == `FB_ADDR_STAT_SEL || paddr == `FB_ADDR_STAT_LOCK;
    wire [7:0] srcs = {1'b0, phase_freq_detector_dn, phase_freq_detector_up, pre_out, adiv_out,
        rdiv_out, ndiv_delayed, 1'b0};
    wire route = (sel[5:3] == 3'h0) ? srcs[sel[2:0]] : 1'b0;
    // Selection is held while the lock bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
            sel <= 6'h00;
        end else if (acc && pwrite) begin
            if (paddr == `FB_ADDR_STAT_LOCK) lock <= pwdata[7];
            if (paddr == `FB_ADDR_STAT_SEL && !lock) sel <= pwdata[7:2];
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_read;
        acc && !pwrite;
    endsequence
    sequence s_osc_still;
        !osc_en [*4];
    endsequence
    a_stat_route: assert property (status_pin == $past(route))
        else $error("status pin differs from selection");
    a_sel_back: assert property (s_read ##0 paddr == `FB_ADDR_STAT_SEL |-> prdata[7:0] == {sel, 2'b00})
        else $error("selector readback wrong");
    a_lock_back: assert property (s_read ##0 paddr == `FB_ADDR_STAT_LOCK |-> prdata[7:0] == {lock, 7'h00})
        else $error("lock readback wrong");
    a_still_out: assert property (s_osc_still |-> !fb_out && !pre_out)
        else $error("divider pulse without input");
    a_bad_addr: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_good_addr: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_hole_zero: assert property (s_read ##0 !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (s_read |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ready_now: assert property (psel |-> pready)
        else $error("ready low while selected");
endmodule // fb_status_checker
bind feedback_prescaler_status_mux fb_status_checker chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_en, .rdiv_out, .ndiv_delayed,
    .phase_freq_detector_up, .phase_freq_detector_dn, .fb_out, .adiv_out, .pre_out, .status_pin);
`default_nettype wire

/* File: bench/tb_feedback_prescaler_status_mux.sv */
// Purpose: Self-checking bench for the prescaler and status pin block
// Assumes: osc_en stays high while feedback periods are timed; B stays 3
// Notes: Periods are counted in osc_en cycles between feedback pulses
`timescale 1ns/1ps
`default_nettype none
`include "fb_prescaler_defs.vh"
module tb_feedback_prescaler_status_mux;
    // ----------------------------------------
    // Signals and notes
    // ----------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic osc_en = 1, rdiv_out = 0, ndiv_delayed = 0, phase_freq_detector_up = 0;
    logic phase_freq_detector_dn = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    wire [31:0] prdata;
    wire pready, pslverr, fb_out, adiv_out, pre_out, status_pin;
    logic [32:0] q_rd[$];
    logic [31:0] q_per[$];
    logic q_st[$];
    logic [15:0] cnt = 0;
    logic [7:0] pcnt = 0, acnt = 0, np, na;
    logic fd;
    // A pulses, prescaler pulses and osc_en cycles of the period just ended
    wire [31:0] seen_per = {acnt + adiv_out, pcnt + pre_out, cnt + osc_en};
    logic [5:0] cur = 0;
    int fail_count = 0, comparisons = 0, cycles = 0, seed = 84737, rnd, i;
    // Control, A value, expected feedback period
    logic [31:0] tbl [9] = '{32'h06010061, 32'h08000001, 32'h09000002, 32'h0f000003,
        32'h01000006, 32'h0a010007, 32'h0300000c, 32'h0402001a, 32'h05010031};
    feedback_prescaler_status_mux dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .osc_en, .rdiv_out, .ndiv_delayed,
        .phase_freq_detector_up, .phase_freq_detector_dn, .fb_out, .adiv_out, .pre_out,
        .status_pin);
    initial forever #12.5 pclk = ~pclk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; reads note the expected error bit and data
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!w) q_rd.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task wait_fb;
        do @(negedge pclk); while (fb_out !== 1'b1);
    endtask
    // Skip settling pulses, then note one full period
    task period(input logic [31:0] n);
        repeat (3) wait_fb;
        q_per.push_back(n);
        @(posedge pclk);
    endtask
    function automatic logic route(input logic [5:0] c);
        logic [7:0] s;
        s = {1'b0, phase_freq_detector_dn, phase_freq_detector_up, pre_out, adiv_out, rdiv_out,
            ndiv_delayed, 1'b0};
        route = (c[5:3] == 3'h0) ? s[c[2:0]] : 1'b0;
    endfunction
    // Random source levels, each noting the pin one cycle later
    task status_run;
        repeat (12) begin
            @(posedge pclk);
            rnd = $random(seed);
            {osc_en, rdiv_out, ndiv_delayed, phase_freq_detector_up,
                phase_freq_detector_dn} <= rnd[4:0];
            @(negedge pclk);
            q_st.push_back(route(cur));
        end
        @(posedge pclk);
        osc_en <= 1;
    endtask
    // ----------------------------------------
    // Watchers and timeout
    // ----------------------------------------
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (psel && penable && pready && !pwrite && q_rd.size() > 0)
            check({pslverr, prdata}, q_rd.pop_front());
        if (fb_out === 1'b1) begin
            if (q_per.size() > 0) check(seen_per, q_per.pop_front());
            cnt <= 0;
            pcnt <= 0;
            acnt <= 0;
        end else begin
            cnt <= cnt + osc_en;
            pcnt <= pcnt + pre_out;
            acnt <= acnt + adiv_out;
        end
        if (cycles == 20000) begin
            fail_count++;
            complete_run;
        end
    end
    always @(posedge pclk) begin
        #1 if (q_st.size() > 0) check(status_pin, q_st.pop_front());
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `FB_ADDR_CTRL, 0, 33'h006);
        apb(0, `FB_ADDR_STAT_SEL, 0, 33'h000);
        apb(0, `FB_ADDR_B_CNT, 0, 33'h003);
        apb(0, 12'h020, 0, 33'h100000000);
        period({8'h00, `FB_B_RST, 16'd96});
        for (i = 0; i < 9; i++) begin
            apb(1, `FB_ADDR_A_CNT, {24'h0, tbl[i][23:16]}, 0);
            apb(1, `FB_ADDR_CTRL, {24'h0, tbl[i][31:24]}, 0);
            // Fixed divide codes are 0, 1 and 7; bypass leaves one prescaler pulse per period
            fd = tbl[i][26:24] < 3'h2 || tbl[i][26:24] == 3'h7;
            np = (tbl[i][27] && fd) ? 8'h01 : `FB_B_RST;
            na = (!fd && tbl[i][23:16] != 8'h00) ? 8'h01 : 8'h00;
            period({na, np, tbl[i][15:0]});
        end
        $display("divider test done");
        for (i = 0; i < 8; i++) begin
            rnd = $random(seed);
            apb(1, `FB_ADDR_STAT_SEL, {24'h0, i[5:0], rnd[1:0]}, 0);
            cur = i[5:0];
            status_run;
        end
        $display("status test done");
        apb(1, `FB_ADDR_STAT_LOCK, 32'h80, 0);
        apb(1, `FB_ADDR_STAT_SEL, 32'h04, 0);
        apb(0, `FB_ADDR_STAT_SEL, 0, 33'h01c);
        status_run;
        apb(1, `FB_ADDR_STAT_LOCK, 32'h00, 0);
        apb(1, `FB_ADDR_STAT_SEL, 32'h08, 0);
        cur = 6'h02;
        apb(0, `FB_ADDR_STAT_SEL, 0, 33'h008);
        status_run;
        $display("lock test done");
        complete_run;
    end
endmodule // tb_feedback_prescaler_status_mux
`default_nettype wire
